// ===== src/bst_map.svh
// Behaviour
// [RQ1] Instruction register is three bits long
// [RQ2] Sample/preload captures pins, leaves normal operation
// [RQ3] External test drives update values, captures inputs
// [RQ4] Bypass inserts one-bit register, one clock delay
// [RQ5] Boundary chain length 522, 621 or 666
// [RQ6] No scan while configuration is in progress; code still scans then when test_disable_i is high
// [RQ7] Undriven test inputs read as one
// [RQ8] Outputs undriven until operating conditions reached
// [RQ9] Open-drain pins drive low or float only; code under extest drives them high or low from the update cells
// [RQ10] Sixteen-state controller, falling-edge data output
// [RQ11] Ones bypass, zeros extest, unassigned bypass
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

// ****************************************
// Widths and lengths
// ****************************************
`define BST_IR_LEN       3
`define BST_CHAIN_LEN    522
`define BST_NUM_PINS     174

// ****************************************
// Instruction codes and reset values
// ****************************************
`define BST_IR_EXTEST    3'h0
`define BST_IR_SAMPLE    3'h5
`define BST_IR_BYPASS    3'h7
`define BST_IR_CAPTURE   3'h1

`endif

// ===== src/bst_pkg.sv
package bst_pkg;

  // ****************************************
  // Controller states and decoded instructions
  // ****************************************
  typedef enum logic [3:0] {
    BST_RESET      = 4'h0,
    BST_IDLE       = 4'h1,
    BST_SEL_DR     = 4'h2,
    BST_CAP_DR     = 4'h3,
    BST_SHIFT_DR   = 4'h4,
    BST_EXIT1_DR   = 4'h5,
    BST_PAUSE_DR   = 4'h6,
    BST_EXIT2_DR   = 4'h7,
    BST_UPD_DR     = 4'h8,
    BST_SEL_IR     = 4'h9,
    BST_CAP_IR     = 4'ha,
    BST_SHIFT_IR   = 4'hb,
    BST_EXIT1_IR   = 4'hc,
    BST_PAUSE_IR   = 4'hd,
    BST_EXIT2_IR   = 4'he,
    BST_UPD_IR     = 4'hf
  } bst_state_t;

  typedef enum logic [1:0] {
    BST_OP_BYPASS  = 2'h0,
    BST_OP_SAMPLE  = 2'h1,
    BST_OP_EXTEST  = 2'h2
  } bst_op_t;

endpackage

// ===== src/bst_fsm.sv
`timescale 1ns/1ps
`include "bst_map.svh"

module bst_fsm (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                ce_i,
  // Sampled link events
  input  wire logic                tck_rise_i,
  input  wire logic                tms_i,
  input  wire logic                trst_b_i,
  // State
  output bst_pkg::bst_state_t      state_o
);

  bst_pkg::bst_state_t state;
  bst_pkg::bst_state_t next_state;

  assign state_o = state;

  // Standard sixteen-state walk on test clock rising edge
  always_comb begin
    next_state = state;
    if (tck_rise_i) begin
      unique case (state)
        bst_pkg::BST_RESET:    next_state = tms_i ? bst_pkg::BST_RESET  : bst_pkg::BST_IDLE; // [RQ10]
        bst_pkg::BST_IDLE:     next_state = tms_i ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
        bst_pkg::BST_SEL_DR:   next_state = tms_i ? bst_pkg::BST_SEL_IR : bst_pkg::BST_CAP_DR;
        bst_pkg::BST_CAP_DR:   next_state = tms_i ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
        bst_pkg::BST_SHIFT_DR: next_state = tms_i ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
        bst_pkg::BST_EXIT1_DR: next_state = tms_i ? bst_pkg::BST_UPD_DR : bst_pkg::BST_PAUSE_DR;
        bst_pkg::BST_PAUSE_DR: next_state = tms_i ? bst_pkg::BST_EXIT2_DR : bst_pkg::BST_PAUSE_DR;
        bst_pkg::BST_EXIT2_DR: next_state = tms_i ? bst_pkg::BST_UPD_DR : bst_pkg::BST_SHIFT_DR;
        bst_pkg::BST_UPD_DR:   next_state = tms_i ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
        bst_pkg::BST_SEL_IR:   next_state = tms_i ? bst_pkg::BST_RESET  : bst_pkg::BST_CAP_IR;
        bst_pkg::BST_CAP_IR:   next_state = tms_i ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
        bst_pkg::BST_SHIFT_IR: next_state = tms_i ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
        bst_pkg::BST_EXIT1_IR: next_state = tms_i ? bst_pkg::BST_UPD_IR : bst_pkg::BST_PAUSE_IR;
        bst_pkg::BST_PAUSE_IR: next_state = tms_i ? bst_pkg::BST_EXIT2_IR : bst_pkg::BST_PAUSE_IR;
        bst_pkg::BST_EXIT2_IR: next_state = tms_i ? bst_pkg::BST_UPD_IR : bst_pkg::BST_SHIFT_IR;
        bst_pkg::BST_UPD_IR:   next_state = tms_i ? bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
      endcase
    end
    if (!trst_b_i) begin
      next_state = bst_pkg::BST_RESET;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= bst_pkg::BST_RESET;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

endmodule

// ===== src/bst_tap.sv
`timescale 1ns/1ps
`include "bst_map.svh"

module bst_tap (
  // Clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           ce_i,
  // Test port pins
  input  wire logic                           tck_i,
  input  wire logic                           tms_i,
  input  wire logic                           tdi_i,
  input  wire logic                           trst_b_i,
  output logic                                tdo_o,
  output logic                                tdo_oe_o,
  // Device state
  input  wire logic                           config_busy_i,
  input  wire logic                           test_disable_i,
  input  wire logic                           power_good_i,
  // Core side of each pin
  input  wire logic [`BST_NUM_PINS-1:0]       core_out_i,
  input  wire logic [`BST_NUM_PINS-1:0]       core_oe_i,
  input  wire logic [`BST_NUM_PINS-1:0]       core_od_i,
  output logic      [`BST_NUM_PINS-1:0]       core_in_o,
  // Package side of each pin
  input  wire logic [`BST_NUM_PINS-1:0]       pin_in_i,
  output logic      [`BST_NUM_PINS-1:0]       pin_out_o,
  output logic      [`BST_NUM_PINS-1:0]       pin_oe_o
);

  localparam int NP = `BST_NUM_PINS;
  localparam int CL = `BST_CHAIN_LEN;

  // ****************************************
  // Link synchronisers
  // ****************************************
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       tck_prev;
  logic       pg1;
  logic       pg2;
  logic [NP-1:0] pin1;
  logic [NP-1:0] pin2;

  // Two-stage capture of link lines, power good and pins; link lines reset high, pins and power good low
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1    <= 5'h1f; // [RQ7]
      sync2    <= 5'h1f; // [RQ7]
      tck_prev <= 1'b1;
      pg1      <= 1'b0;
      pg2      <= 1'b0;
      pin1     <= '0;
      pin2     <= '0;
    end else if (ce_i) begin
      sync1    <= {tck_i, tms_i, tdi_i, trst_b_i, config_busy_i};
      sync2    <= sync1;
      tck_prev <= sync2[4];
      pg1      <= power_good_i;
      pg2      <= pg1;
      pin1     <= pin_in_i;
      pin2     <= pin1;
    end
  end

  logic s_tck;
  logic s_tms;
  logic s_tdi;
  logic s_trst_b;
  logic s_busy;
  logic tck_rise;
  logic tck_fall;
  logic scan_ok;

  assign s_tck    = sync2[4];
  assign s_tms    = sync2[3];
  assign s_tdi    = sync2[2];
  assign s_trst_b = sync2[1];
  assign s_busy   = sync2[0];
  assign tck_rise = s_tck & ~tck_prev;
  assign tck_fall = ~s_tck & tck_prev;
  // Scan blocked mid-configuration unless test support is off
  assign scan_ok  = ~s_busy | test_disable_i; // [RQ6]

  // ****************************************
  // Controller
  // ****************************************
  bst_pkg::bst_state_t state;

  bst_fsm u_fsm (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .tck_rise_i (tck_rise & scan_ok),
    .tms_i      (s_tms),
    .trst_b_i   (s_trst_b),
    .state_o    (state)
  );

  // Instruction decode
  function automatic bst_pkg::bst_op_t decode(input logic [`BST_IR_LEN-1:0] code);
    unique case (code)
      `BST_IR_EXTEST: decode = bst_pkg::BST_OP_EXTEST; // [RQ11]
      `BST_IR_SAMPLE: decode = bst_pkg::BST_OP_SAMPLE;
      default:        decode = bst_pkg::BST_OP_BYPASS; // [RQ11]
    endcase
  endfunction

  // ****************************************
  // Shift, capture and update
  // ****************************************
  logic [`BST_IR_LEN-1:0] ir_sh;
  logic [`BST_IR_LEN-1:0] ir;
  logic                   byp;
  logic [CL-1:0]          bsr;
  logic [CL-1:0]          upd;
  logic                   tdo;
  logic                   tdo_oe;
  logic [`BST_IR_LEN-1:0] next_ir_sh;
  logic [`BST_IR_LEN-1:0] next_ir;
  logic                   next_byp;
  logic [CL-1:0]          next_bsr;
  logic [CL-1:0]          next_upd;
  logic                   next_tdo;
  logic                   next_tdo_oe;
  logic [CL-1:0]          cap_vec;
  bst_pkg::bst_op_t       op;

  assign op = decode(ir);

  // Capture vector: per pin input, output and enable cells
  generate
    for (genvar g = 0; g < NP; g++) begin : g_cell
      assign cap_vec[3*g]   = pin2[g];                                              // [RQ2] [RQ3]
      assign cap_vec[3*g+1] = (op == bst_pkg::BST_OP_EXTEST) ? upd[3*g+1] : core_out_i[g];
      assign cap_vec[3*g+2] = (op == bst_pkg::BST_OP_EXTEST) ? upd[3*g+2] : core_oe_i[g];
    end
  endgenerate

  // Register actions per controller state
  always_comb begin
    next_ir_sh  = ir_sh;
    next_ir     = ir;
    next_byp    = byp;
    next_bsr    = bsr;
    next_upd    = upd;
    next_tdo    = tdo;
    next_tdo_oe = tdo_oe;
    if (state == bst_pkg::BST_RESET) begin
      next_ir = `BST_IR_BYPASS;
    end
    if (tck_rise && scan_ok) begin
      unique case (state)
        bst_pkg::BST_CAP_IR:   next_ir_sh = `BST_IR_CAPTURE;
        bst_pkg::BST_SHIFT_IR: next_ir_sh = {s_tdi, ir_sh[`BST_IR_LEN-1:1]}; // [RQ1]
        bst_pkg::BST_UPD_IR:   next_ir = ir_sh;
        bst_pkg::BST_CAP_DR: begin
          if (op == bst_pkg::BST_OP_BYPASS) next_byp = 1'b0;
          else next_bsr = cap_vec; // [RQ2] [RQ3]
        end
        bst_pkg::BST_SHIFT_DR: begin
          if (op == bst_pkg::BST_OP_BYPASS) next_byp = s_tdi; // [RQ4]
          else next_bsr = {s_tdi, bsr[CL-1:1]}; // [RQ5]
        end
        bst_pkg::BST_UPD_DR: begin
          if (op != bst_pkg::BST_OP_BYPASS) next_upd = bsr; // [RQ2]
        end
        default: ;
      endcase
    end
    // Data out moves on the falling edge, floats outside shifts
    if (tck_fall) begin
      next_tdo_oe = (state == bst_pkg::BST_SHIFT_IR) || (state == bst_pkg::BST_SHIFT_DR); // [RQ10]
      if (state == bst_pkg::BST_SHIFT_IR) next_tdo = ir_sh[0];
      else if (op == bst_pkg::BST_OP_BYPASS) next_tdo = byp; // [RQ4]
      else next_tdo = bsr[0];
    end
    if (!scan_ok) begin
      next_tdo_oe = 1'b0; // [RQ6]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ir_sh  <= `BST_IR_CAPTURE;
      ir     <= `BST_IR_BYPASS;
      byp    <= 1'b0;
      bsr    <= '0;
      upd    <= '0;
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (ce_i) begin
      ir_sh  <= next_ir_sh;
      ir     <= next_ir;
      byp    <= next_byp;
      bsr    <= next_bsr;
      upd    <= next_upd;
      tdo    <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  logic [NP-1:0] next_pin_out;
  logic [NP-1:0] next_pin_oe;
  logic [NP-1:0] next_core_in;

  // Output mux: test pattern under extest, else core
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      next_core_in[i] = pin2[i];
      if (op == bst_pkg::BST_OP_EXTEST) begin
        next_pin_out[i] = upd[3*i+1]; // [RQ3]
        next_pin_oe[i]  = upd[3*i+2]; // [RQ3]
      end else if (core_od_i[i]) begin
        next_pin_out[i] = 1'b0;                      // [RQ9]
        next_pin_oe[i]  = core_oe_i[i] & ~core_out_i[i]; // [RQ9]
      end else begin
        next_pin_out[i] = core_out_i[i];
        next_pin_oe[i]  = core_oe_i[i];
      end
      if (!pg2) begin
        next_pin_oe[i] = 1'b0; // [RQ8]
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_out_o <= '0;
      pin_oe_o  <= '0; // [RQ8]
      core_in_o <= '0;
      tdo_o     <= 1'b0;
      tdo_oe_o  <= 1'b0;
    end else if (ce_i) begin
      pin_out_o <= next_pin_out;
      pin_oe_o  <= next_pin_oe;
      core_in_o <= next_core_in;
      tdo_o     <= next_tdo;
      tdo_oe_o  <= next_tdo_oe & pg2; // [RQ8]
    end
  end

endmodule

// ===== sim/bst_ctl.sv
`timescale 1ns/1ps
// ********
// Test controller model
// ********
module bst_ctl (
  // Clock
  input  wire logic clk_i,
  // Test port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_b_o,
  input  wire logic tdo_i
);
  // Released lines rest at pull-up level
  initial begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_b_o = 1'b1;
  end
  // One 160 ns test clock, tdo taken late in high phase
  task automatic tk(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    tck_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    q = tdo_i;
    @(posedge clk_i);
  endtask
  // Leave reset state for idle
  task automatic idle;
    logic q;
    tk(1'b0, 1'b1, q);
  endtask
  // Scan n bits LSB first, idle to idle
  task automatic scan(input logic ir, input int n, input logic [521:0] din, output logic [521:0] dout);
    logic q;
    dout = '0;
    tk(1'b1, 1'b1, q);
    if (ir) tk(1'b1, 1'b1, q);
    tk(1'b0, 1'b1, q);
    tk(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tk(1'b1, 1'b1, q);
    tk(1'b0, 1'b1, q);
  endtask
  // Test reset pulse, then idle
  task automatic trst;
    trst_b_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    trst_b_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    idle();
  endtask
endmodule

// ===== sim/bst_tap_properties.sv
`timescale 1ns/1ps
`include "bst_map.svh"
// ********
// Port checker
// ********
module bst_tap_chk (
  // Clock and reset
  input wire logic                     clk_i,
  input wire logic                     rst_b_i,
  // Watched ports
  input wire logic                     tck_i,
  input wire logic                     trst_b_i,
  input wire logic                     tdo_o,
  input wire logic                     tdo_oe_o,
  input wire logic                     config_busy_i,
  input wire logic                     test_disable_i,
  input wire logic                     power_good_i,
  input wire logic [`BST_NUM_PINS-1:0] pin_in_i,
  input wire logic [`BST_NUM_PINS-1:0] core_in_o,
  input wire logic [`BST_NUM_PINS-1:0] pin_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Gating, timing and pin paths
  AST_PIN_QUIET: assert property (!power_good_i [*4] |-> pin_oe_o == '0)
    else $error("pin enable before power good");
  AST_TDO_QUIET: assert property (!power_good_i [*4] |-> !tdo_oe_o)
    else $error("tdo enable before power good");
  AST_CFG_BLOCK: assert property ((config_busy_i && !test_disable_i) [*4] |-> !tdo_oe_o)
    else $error("tdo enabled during configuration");
  // Busy seen through two sync stages, disable taken directly
  AST_CFG_START: assert property ($rose(tdo_oe_o) |-> !$past(config_busy_i, 3) || $past(test_disable_i))
    else $error("scan started during configuration");
  AST_TDO_FALL: assert property ($changed(tdo_o) |-> !$past(tck_i, 2))
    else $error("tdo changed after rising test clock");
  AST_OE_FALL: assert property ($changed(tdo_oe_o) && power_good_i && !config_busy_i |-> !$past(tck_i, 2))
    else $error("tdo enable changed after rising test clock");
  AST_TRST: assert property (!trst_b_i [*8] |-> !tdo_oe_o)
    else $error("tdo driven in test reset");
  AST_PIN_IN: assert property ($stable(pin_in_i) [*6] |-> core_in_o == pin_in_i)
    else $error("core input not following pin");
  // Main scenarios
  COV_SCAN: cover property ($rose(tdo_oe_o));
  COV_TRST: cover property (!trst_b_i [*8]);
  COV_DIS: cover property (config_busy_i && test_disable_i && tdo_oe_o);
endmodule

bind bst_tap bst_tap_chk bst_tap_chk_inst (.clk_i, .rst_b_i, .tck_i, .trst_b_i, .tdo_o, .tdo_oe_o, .config_busy_i,
  .test_disable_i, .power_good_i, .pin_in_i, .core_in_o, .pin_oe_o);

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "bst_map.svh"
module tb;
  localparam int NP = `BST_NUM_PINS;
  logic          clk_i = 1'b0, rst_b_i = 1'b0, busy = 1'b0, tdis = 1'b0, pg = 1'b0;
  logic          tck, tms, tdi, trst_b, tdo, tdo_oe;
  logic [NP-1:0] c_out = {58{3'h6}}, c_oe = {58{3'h3}}, c_od = '0, p_in = {58{3'h5}};
  logic [NP-1:0] core_in, p_out, p_oe, eo = {87{2'h1}}, ee = {87{2'h2}};
  logic [521:0]  pre = {87{6'h22}}, got;
  int            fails = 0, checks = 0;
  // Clock
  always #10 clk_i = ~clk_i;
  // Device and controller
  bst_tap bst_tap_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_b_i(trst_b), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .config_busy_i(busy), .test_disable_i(tdis),
    .power_good_i(pg), .core_out_i(c_out), .core_oe_i(c_oe), .core_od_i(c_od), .core_in_o(core_in),
    .pin_in_i(p_in), .pin_out_o(p_out), .pin_oe_o(p_oe));
  // Released tdo reads the pull-up level
  bst_ctl bst_ctl_inst (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_b_o(trst_b),
    .tdo_i(tdo_oe ? tdo : 1'b1));
  // Compare and report
  task automatic chk(input logic [521:0] g, input logic [521:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pins(input logic [NP-1:0] o, input logic [NP-1:0] e);
    repeat (8) @(posedge clk_i);
    chk(522'(p_out), 522'(o));
    chk(522'(p_oe), 522'(e));
  endtask
  // Expected capture: input cells from pads, rest from core or base
  function automatic logic [521:0] cap(input logic [521:0] base, input logic smp);
    logic [521:0] r;
    r = base;
    for (int k = 0; k < NP; k++) begin
      r[3*k] = p_in[k];
      if (smp) r[3*k+1 +: 2] = {c_oe[k], c_out[k]};
    end
    return r;
  endfunction
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_power;
    repeat (8) @(posedge clk_i);
    chk(522'(p_oe), '0);
    pg <= 1'b1;
    c_od <= '1;
    pins('0, c_oe & ~c_out);
    c_od <= '0;
    pins(c_out, c_oe);
    $display("power done");
  endtask
  task automatic t_bypass;
    bst_ctl_inst.idle();
    bst_ctl_inst.scan(1'b1, 3, 522'h3, got);
    chk(got, 522'h1);
    bst_ctl_inst.scan(1'b0, 8, 522'hb4, got);
    chk(got, 522'h68);
    $display("bypass done");
  endtask
  task automatic t_sample;
    bst_ctl_inst.scan(1'b1, 3, 522'h5, got);
    bst_ctl_inst.scan(1'b0, 522, pre, got);
    chk(got, cap('0, 1'b1));
    pins(c_out, c_oe);
    chk(522'(core_in), 522'(p_in));
    $display("sample done");
  endtask
  task automatic t_extest;
    bst_ctl_inst.scan(1'b1, 3, 522'h0, got);
    pins(eo, ee);
    p_in <= ~p_in;
    repeat (8) @(posedge clk_i);
    bst_ctl_inst.scan(1'b0, 522, pre, got);
    chk(got, cap(pre, 1'b0));
    $display("extest done");
  endtask
  task automatic t_trst;
    bst_ctl_inst.trst();
    pins(c_out, c_oe);
    $display("trst done");
  endtask
  task automatic t_config;
    busy <= 1'b1;
    repeat (4) @(posedge clk_i);
    bst_ctl_inst.scan(1'b1, 3, 522'h0, got);
    chk(got, 522'h7);
    pins(c_out, c_oe);
    tdis <= 1'b1;
    repeat (4) @(posedge clk_i);
    bst_ctl_inst.scan(1'b1, 3, 522'h0, got);
    pins(eo, ee);
    $display("config done");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_power();
    t_bypass();
    t_sample();
    t_extest();
    t_trst();
    t_config();
    close_out();
  end
  // Hang limit
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    close_out();
  end
endmodule
